// File: hw/aar_map.vh
`ifndef AAR_MAP_VH
`define AAR_MAP_VH

// ****************************************************************
// Register indices; the byte address is four times the index.
// ****************************************************************
`define AAR_IDX_ADV      6'h04
`define AAR_IDX_LPA      6'h05
`define AAR_IDX_STS      6'h08
`define AAR_IDX_ISTS     6'h09
`define AAR_IDX_IMSK     6'h0A

// ****************************************************************
// Advertisement and partner word fields.
// ****************************************************************
`define AAR_BIT_NXTPG    15
`define AAR_BIT_ACK      14
`define AAR_BIT_REMOTE_FAULT_STATUS     13
`define AAR_BIT_FD       6
`define AAR_BIT_HD       5
`define AAR_SEL_MSB      4
`define AAR_SEL_802_3    5'h01
`define AAR_SEL_MMEDIA   5'h02
`define AAR_ADV_RST_REMOTE_FAULT_STATUS 1'h0
`define AAR_ADV_RST_FD   1'h1
`define AAR_ADV_RST_HD   1'h1

// ****************************************************************
// Status and event bits.
// ****************************************************************
`define AAR_STS_DONE     5
`define AAR_STS_REMOTE_FAULT_STATUS     4
`define AAR_STS_MMEDIA   1
`define AAR_STS_SEL_OK   0
`define AAR_EV_PAGE      0
`define AAR_EV_REMOTE_FAULT_STATUS      1
`define AAR_EV_NXTPG     2
`define AAR_EV_DONE      3
`define AAR_EV_W         4
`define AAR_EV_RST       4'h0
`define AAR_DONE_RST     1'h1

// ****************************************************************
// Bus answers.
// ****************************************************************
`define AAR_RESP_OKAY    2'h0
`define AAR_RESP_SLVERR  2'h2

`endif

// File: hw/aar_lcw_capture.v
`timescale 1ns/1ns
`include "aar_map.vh"

module aar_lcw_capture (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [15:0] rx_lcw,
	input  wire        rx_lcw_valid,
	input  wire        neg_active,
	output reg  [15:0] lpa_ff,
	output reg         done_ff,
	output reg         sel_ok_ff,
	output reg         page_ev_ff,
	output reg         remote_fault_status_ev_ff,
	output reg         nxtpg_ev_ff,
	output reg         done_ev_ff
);

// ****************************************************************
// Partner word capture.
// ****************************************************************
// Every accepted word is stored whole, reserved bits included, so
// software sees exactly what the partner sent.
// Done resets high, its level while no negotiation runs, so that no
// false finish event follows the release of reset.
always @(posedge aclk) begin
	if (!aresetn) begin
		lpa_ff      <= 16'h0000;
		done_ff     <= `AAR_DONE_RST;
		sel_ok_ff   <= 1'b0;
		page_ev_ff  <= 1'b0;
		remote_fault_status_ev_ff  <= 1'b0;
		nxtpg_ev_ff <= 1'b0;
		done_ev_ff  <= 1'b0;
	end else begin
		done_ff     <= ~neg_active; // RULE_13
		done_ev_ff  <= neg_active == 1'b0 && done_ff == 1'b0;
		page_ev_ff  <= rx_lcw_valid;
		remote_fault_status_ev_ff  <= rx_lcw_valid & rx_lcw[`AAR_BIT_REMOTE_FAULT_STATUS] &
			~lpa_ff[`AAR_BIT_REMOTE_FAULT_STATUS];
		// The further page is flagged but never fetched.
		nxtpg_ev_ff <= rx_lcw_valid & rx_lcw[`AAR_BIT_NXTPG]; // RULE_08
		if (rx_lcw_valid) begin
			lpa_ff    <= rx_lcw; // RULE_15 RULE_10 RULE_11 RULE_09
			sel_ok_ff <= rx_lcw[`AAR_SEL_MSB:0] == `AAR_SEL_802_3; // RULE_12
		end
	end
end

endmodule

// File: hw/aar_regs.v
// How it works
// RULE_01: Advertisement bit 15 reads 0 and no next page is ever sent or taken.
// RULE_02: Bit 14 of both registers belongs to the negotiation process only.
// RULE_03: Setting advertisement bit 13 sends a remote fault to the partner.
// RULE_04: Advertisement bits 12 to 5 go out as the local ability field.
// RULE_05: Of the ability bits, only advertisement bits 6 and 5 can be set by software.
// RULE_06: Advertisement bits 12 to 7 always read 0 and ignore writes.
// RULE_07: The advertisement selector bits 4 to 0 are fixed at 00001.
// RULE_08: Partner bit 15 shows a further page that is never received.
// RULE_09: Partner bit 13 reads 1 when the partner reports a remote fault.
// RULE_10: Partner bits 12 to 10 are stored as received, uninterpreted.
// RULE_11: Partner bits 9 to 5 show the partner's five technology abilities.
// RULE_12: Partner selector 00001 is supported; 00010 means multimedia.
// RULE_13: Partner contents are valid only once negotiation is done.
// RULE_14: The status remote fault bit mirrors the latest partner fault bit.
// RULE_15: The partner register is read-only and updated per accepted word.
`timescale 1ns/1ns
`include "aar_map.vh"

module aar_regs (
	input  wire        aclk,
	input  wire        aresetn,
	input  wire [7:0]  s_axi_awaddr,
	input  wire [2:0]  s_axi_awprot,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire [2:0]  s_axi_arprot,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire [15:0] rx_lcw,
	input  wire        rx_lcw_valid,
	input  wire        neg_active,
	input  wire        neg_ack,
	output reg  [15:0] tx_lcw_ff,
	output reg         irq_ff
);

// ****************************************************************
// Address decode helpers.
// ****************************************************************
function is_mapped;
	input [7:0] addr;
	reg   [5:0] idx;
	begin
		idx = addr[7:2];
		is_mapped = (idx == `AAR_IDX_ADV) || (idx == `AAR_IDX_LPA) ||
			(idx == `AAR_IDX_STS) || (idx == `AAR_IDX_ISTS) ||
			(idx == `AAR_IDX_IMSK);
	end
endfunction

function hits;
	input [7:0] addr;
	input [5:0] idx;
	begin
		hits = addr[7:2] == idx;
	end
endfunction

// ****************************************************************
// Local state.
// ****************************************************************
reg        adv_remote_fault_status_ff;
reg        adv_fd_ff;
reg        adv_hd_ff;
reg        ack_ff;
reg  [3:0] ists_ff;
reg  [3:0] imsk_ff;
reg        aw_hold_ff;
reg  [7:0] awaddr_ff;
reg        w_hold_ff;
reg [31:0] wdata_ff;
reg  [3:0] wstrb_ff;

wire [15:0] lpa;
wire        done;
wire        sel_ok;
wire        page_ev;
wire        remote_fault_status_ev;
wire        nxtpg_ev;
wire        done_ev;
wire        b_done;
wire        r_done;

reg  [15:0] adv_word;
reg  [15:0] sts_word;
reg  [3:0]  ev_vec;
reg  [3:0]  nxt_ists;
reg         wr_go;
reg  [31:0] nxt_rdata;

assign b_done = s_axi_bvalid & s_axi_bready;
assign r_done = s_axi_rvalid & s_axi_rready;

aar_lcw_capture u_capture (
	.aclk         (aclk),
	.aresetn      (aresetn),
	.rx_lcw       (rx_lcw),
	.rx_lcw_valid (rx_lcw_valid),
	.neg_active   (neg_active),
	.lpa_ff       (lpa),
	.done_ff      (done),
	.sel_ok_ff    (sel_ok),
	.page_ev_ff   (page_ev),
	.remote_fault_status_ev_ff   (remote_fault_status_ev),
	.nxtpg_ev_ff  (nxtpg_ev),
	.done_ev_ff   (done_ev)
);

// ****************************************************************
// Advertisement word as read and as sent.
// ****************************************************************
// Bit 14 carries the negotiation acknowledge; software may see it
// change at any time and must not rely on it.
always @* begin
	adv_word = 16'h0000;
	adv_word[`AAR_BIT_NXTPG] = 1'b0; // RULE_01
	adv_word[`AAR_BIT_ACK] = ack_ff; // RULE_02
	adv_word[`AAR_BIT_REMOTE_FAULT_STATUS] = adv_remote_fault_status_ff;
	adv_word[`AAR_BIT_FD] = adv_fd_ff;
	adv_word[`AAR_BIT_HD] = adv_hd_ff;
	adv_word[`AAR_SEL_MSB:0] = `AAR_SEL_802_3; // RULE_07
end

// ****************************************************************
// Status word.
// ****************************************************************
always @* begin
	sts_word = 16'h0000;
	sts_word[`AAR_STS_DONE] = done; // RULE_13
	sts_word[`AAR_STS_REMOTE_FAULT_STATUS] = lpa[`AAR_BIT_REMOTE_FAULT_STATUS]; // RULE_14
	sts_word[`AAR_STS_MMEDIA] = lpa[`AAR_SEL_MSB:0] == `AAR_SEL_MMEDIA;
	sts_word[`AAR_STS_SEL_OK] = sel_ok; // RULE_12
end

// ****************************************************************
// Events and interrupt.
// ****************************************************************
always @* begin
	ev_vec = `AAR_EV_RST;
	ev_vec[`AAR_EV_PAGE] = page_ev;
	ev_vec[`AAR_EV_REMOTE_FAULT_STATUS] = remote_fault_status_ev;
	ev_vec[`AAR_EV_NXTPG] = nxtpg_ev;
	ev_vec[`AAR_EV_DONE] = done_ev;
	wr_go = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
	nxt_ists = ists_ff;
	if (wr_go && hits(awaddr_ff, `AAR_IDX_ISTS) && wstrb_ff[0])
		nxt_ists = ists_ff & ~wdata_ff[`AAR_EV_W-1:0];
	// A new event outranks a clear in the same cycle.
	nxt_ists = nxt_ists | ev_vec;
end

always @(posedge aclk) begin
	if (!aresetn)
		ists_ff <= `AAR_EV_RST;
	else
		ists_ff <= nxt_ists;
end

// ****************************************************************
// Interrupt output.
// ****************************************************************
// The level follows the next status value, so it never lags the
// status bit that causes it.
always @(posedge aclk) begin
	if (!aresetn)
		irq_ff <= 1'b0;
	else
		irq_ff <= |(nxt_ists & imsk_ff);
end

// ****************************************************************
// Write address channel.
// ****************************************************************
// Address and data are latched independently; the write is done
// one cycle after both are held, and the response waits on bready.
// Ready stays low until the response is taken, which keeps a second
// write from overtaking the first.
always @(posedge aclk) begin
	if (!aresetn) begin
		aw_hold_ff    <= 1'b0;
		awaddr_ff     <= 8'h00;
		s_axi_awready <= 1'b0;
	end else if (s_axi_awvalid && s_axi_awready) begin
		aw_hold_ff    <= 1'b1;
		awaddr_ff     <= s_axi_awaddr;
		s_axi_awready <= 1'b0;
	end else if (b_done) begin
		aw_hold_ff    <= 1'b0;
		s_axi_awready <= 1'b1;
	end else if (!aw_hold_ff) begin
		s_axi_awready <= 1'b1;
	end
end

// ****************************************************************
// Write data channel.
// ****************************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		w_hold_ff    <= 1'b0;
		wdata_ff     <= 32'h0000_0000;
		wstrb_ff     <= 4'h0;
		s_axi_wready <= 1'b0;
	end else if (s_axi_wvalid && s_axi_wready) begin
		w_hold_ff    <= 1'b1;
		wdata_ff     <= s_axi_wdata;
		wstrb_ff     <= s_axi_wstrb;
		s_axi_wready <= 1'b0;
	end else if (b_done) begin
		w_hold_ff    <= 1'b0;
		s_axi_wready <= 1'b1;
	end else if (!w_hold_ff) begin
		s_axi_wready <= 1'b1;
	end
end

// ****************************************************************
// Write response channel.
// ****************************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_bvalid <= 1'b0;
		s_axi_bresp  <= `AAR_RESP_OKAY;
	end else if (wr_go) begin
		s_axi_bvalid <= 1'b1;
		s_axi_bresp  <= is_mapped(awaddr_ff) ?
			`AAR_RESP_OKAY : `AAR_RESP_SLVERR;
	end else if (b_done) begin
		s_axi_bvalid <= 1'b0;
	end
end

// ****************************************************************
// Writable registers.
// ****************************************************************
// Only the fault request and the two duplex bits have storage, so
// the other ability bits can never be advertised. A write to the
// partner or status register is answered OKAY and has no effect.
always @(posedge aclk) begin
	if (!aresetn) begin
		adv_remote_fault_status_ff <= `AAR_ADV_RST_REMOTE_FAULT_STATUS;
		adv_fd_ff   <= `AAR_ADV_RST_FD;
		adv_hd_ff   <= `AAR_ADV_RST_HD;
	end else if (wr_go && hits(awaddr_ff, `AAR_IDX_ADV)) begin
		if (wstrb_ff[1])
			adv_remote_fault_status_ff <= wdata_ff[`AAR_BIT_REMOTE_FAULT_STATUS]; // RULE_03
		if (wstrb_ff[0]) begin
			adv_fd_ff <= wdata_ff[`AAR_BIT_FD]; // RULE_05
			adv_hd_ff <= wdata_ff[`AAR_BIT_HD]; // RULE_05
		end
	end
end

// ****************************************************************
// Interrupt mask.
// ****************************************************************
always @(posedge aclk) begin
	if (!aresetn)
		imsk_ff <= `AAR_EV_RST;
	else if (wr_go && hits(awaddr_ff, `AAR_IDX_IMSK) && wstrb_ff[0])
		imsk_ff <= wdata_ff[`AAR_EV_W-1:0];
end

// ****************************************************************
// Transmitted link code word.
// ****************************************************************
always @(posedge aclk) begin
	if (!aresetn) begin
		ack_ff    <= 1'b0;
		tx_lcw_ff <= 16'h0000;
	end else begin
		ack_ff    <= neg_ack;
		// Bits 12 to 7 have no storage and always go out as zero.
		tx_lcw_ff <= adv_word; // RULE_04 RULE_06 RULE_01
	end
end

// ****************************************************************
// Read channel.
// ****************************************************************
always @* begin
	nxt_rdata = 32'h0000_0000;
	if (hits(s_axi_araddr, `AAR_IDX_ADV))
		nxt_rdata[15:0] = adv_word; // RULE_06
	else if (hits(s_axi_araddr, `AAR_IDX_LPA))
		nxt_rdata[15:0] = lpa; // RULE_15
	else if (hits(s_axi_araddr, `AAR_IDX_STS))
		nxt_rdata[15:0] = sts_word;
	else if (hits(s_axi_araddr, `AAR_IDX_ISTS))
		nxt_rdata[`AAR_EV_W-1:0] = ists_ff;
	else if (hits(s_axi_araddr, `AAR_IDX_IMSK))
		nxt_rdata[`AAR_EV_W-1:0] = imsk_ff;
end

// Only one read is taken at a time; ready comes back with the
// handshake that ends it.
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_arready <= 1'b0;
	end else if (r_done || !s_axi_rvalid) begin
		s_axi_arready <= 1'b1;
	end
end

// ****************************************************************
// Read data channel.
// ****************************************************************
// The data are latched when the address is taken, so they stand
// unchanged while the master keeps rready low.
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_rvalid <= 1'b0;
		s_axi_rdata  <= 32'h0000_0000;
		s_axi_rresp  <= `AAR_RESP_OKAY;
	end else if (s_axi_arvalid && s_axi_arready) begin
		s_axi_rvalid <= 1'b1;
		s_axi_rdata  <= nxt_rdata;
		s_axi_rresp  <= is_mapped(s_axi_araddr) ?
			`AAR_RESP_OKAY : `AAR_RESP_SLVERR;
	end else if (r_done) begin
		s_axi_rvalid <= 1'b0;
	end
end

endmodule

// File: tb/aar_regs_properties.sv
`timescale 1ns/1ns
module aar_regs_chk (
	input logic        aclk,
	input logic        aresetn,
	input logic        s_axi_awvalid,
	input logic        s_axi_awready,
	input logic [1:0]  s_axi_bresp,
	input logic        s_axi_bvalid,
	input logic        s_axi_bready,
	input logic        s_axi_arvalid,
	input logic        s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic        s_axi_rvalid,
	input logic        s_axi_rready,
	input logic [15:0] tx_lcw_ff,
	input logic        irq_ff
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ****************************************************************
	// Properties.
	// ****************************************************************
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=>
		!s_axi_awready [*2]) else $error("awready early");
	a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read late");
	a_rd_upper: assert property (s_axi_rvalid |->
		s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
	a_bresp_code: assert property (s_axi_bvalid |->
		!s_axi_bresp[0]) else $error("bad bresp");
	a_adv_zero: assert property (tx_lcw_ff[15] == 1'b0 &&
		tx_lcw_ff[12:7] == 6'h00) else $error("fixed zeros sent");
	a_adv_sel: assert property ($past(aresetn) |->
		tx_lcw_ff[4:0] == 5'h01) else $error("selector wrong");
	a_irq_clear: assert property ($fell(irq_ff) |->
		s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq fell alone");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(irq_ff));
endmodule

bind aar_regs aar_regs_chk i_chk (.*);

// File: tb/aar_lp_model.sv
`timescale 1ns/1ns
module aar_lp_model (
	input  wire         aclk,
	output logic [15:0] rx_lcw,
	output logic        rx_lcw_valid,
	output logic        neg_active
);
	initial begin
		rx_lcw = 16'h0000;
		rx_lcw_valid = 1'b0;
		neg_active = 1'b0;
	end
	// Between pulses the word shows its inverse, so stale data is caught.
	task automatic send(input logic [15:0] w, input int gap);
		neg_active <= 1'b1;
		repeat (gap) @(posedge aclk);
		rx_lcw <= w;
		rx_lcw_valid <= 1'b1;
		@(posedge aclk);
		rx_lcw <= ~w;
		rx_lcw_valid <= 1'b0;
		@(posedge aclk);
		neg_active <= 1'b0;
	endtask
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00;
	logic [2:0]  s_axi_awprot = 3'h0;
	logic        s_axi_awvalid = 1'b0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_wvalid = 1'b0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready = 1'b0;
	logic [7:0]  s_axi_araddr = 8'h00;
	logic [2:0]  s_axi_arprot = 3'h0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready = 1'b0;
	logic [15:0] rx_lcw;
	logic        rx_lcw_valid;
	logic        neg_active;
	logic        neg_ack = 1'b0;
	logic [15:0] tx_lcw_ff;
	logic        irq_ff;
	logic [15:0] words [3] = '{16'h0022, 16'hBFE1, 16'h0001};
	logic [15:0] w;
	logic        prev;
	int          errors = 0;
	int          cmp_count = 0;

	aar_regs i_aar_regs (.*);
	aar_lp_model i_aar_lp_model (.*);

	initial begin
		forever #2 aclk = ~aclk;
	end

	// ****************************************************************
	// Bus tasks.
	// ****************************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Ready is raised late on purpose, so the answer has to stand.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, ed);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask

	task automatic report_and_stop;
		$display("compares=%0d errors=%0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		report_and_stop();
	end

	// ****************************************************************
	// Tests.
	// ****************************************************************
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(8'h10, 32'h0061, 2'h0);
		chk({16'h0, tx_lcw_ff}, 32'h0061);
		wr(8'h10, 32'hFFFFFFFF, 2'h0);
		rd(8'h10, 32'h2061, 2'h0);
		chk({16'h0, tx_lcw_ff}, 32'h2061);
		wr(8'h10, 32'h00000040, 2'h0);
		rd(8'h10, 32'h0041, 2'h0);
		neg_ack <= 1'b1;
		repeat (3) @(posedge aclk);
		chk({16'h0, tx_lcw_ff}, 32'h4041);
		neg_ack <= 1'b0;
		$display("advertisement test done");
		prev = 1'b0;
		for (int i = 0; i < 3; i++) begin
			w = words[i];
			wr(8'h24, 32'hF, 2'h0);
			i_aar_lp_model.send(w, 1 + 6 * i);
			repeat (2) @(posedge aclk);
			rd(8'h14, {16'h0, w}, 2'h0);
			wr(8'h14, 32'hFFFF, 2'h0);
			rd(8'h14, {16'h0, w}, 2'h0);
			rd(8'h20, {26'h0, 1'b1, w[13], 2'b00, w[4:0] == 5'h02,
				w[4:0] == 5'h01}, 2'h0);
			rd(8'h24, {28'h0, 1'b1, w[15], w[13] & ~prev, 1'b1},
				2'h0);
			chk({31'h0, irq_ff}, 32'h0);
			prev = w[13];
		end
		$display("partner test done");
		wr(8'h28, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq_ff}, 32'h1);
		wr(8'h24, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk({31'h0, irq_ff}, 32'h0);
		rd(8'h24, 32'h8, 2'h0);
		rd(8'h28, 32'h1, 2'h0);
		rd(8'h3C, 32'h0, 2'h2);
		wr(8'h3C, 32'hFFFF, 2'h2);
		$display("interrupt test done");
		report_and_stop();
	end
endmodule
